// *** logic/rtcctl_pkg.sv ***
`default_nettype none
package rtcctl_pkg;

  // Register addresses on the byte-wide register port
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h08;
  localparam logic [7:0] ADDR_SUPPLY   = 8'h09;
  localparam logic [7:0] ADDR_BAT_TRIP = 8'h0a;
  localparam logic [7:0] ADDR_TRIM     = 8'h0b;

  // Reset values
  localparam logic [7:0] RST_IRQ_CTRL = 8'h01;
  localparam logic [7:0] RST_SUPPLY   = 8'h00;
  localparam logic [7:0] RST_BAT_TRIP = 8'h00;
  localparam logic [7:0] RST_TRIM     = 8'h00;
  localparam logic [7:0] RDATA_NONE   = 8'h00;

  // Field positions in supply_control
  localparam int SUPPLY_STAMP_CLR_BIT = 7;
  localparam int SUPPLY_TRIP_MSB      = 2;

  // Clock output select codes
  localparam logic [3:0] FO_OFF     = 4'h0;
  localparam logic [3:0] FO_OSC     = 4'h1;
  localparam logic [3:0] FO_DIV_4K  = 4'h2;
  localparam logic [3:0] FO_DIV_1K  = 4'h3;
  localparam int         TAP_4K     = 2;
  localparam int         TAP_1K     = 4;
  localparam int         TAP_OFFSET = 4;
  localparam int         DIV_WIDTH  = 20;

  // Coarse digital trim codes and spans, in tenths of ppm
  localparam logic [1:0] DTRIM_OFF   = 2'h0;
  localparam logic [1:0] DTRIM_PLUS  = 2'h1;
  localparam logic [1:0] DTRIM_ZERO  = 2'h2;
  localparam logic [1:0] DTRIM_MINUS = 2'h3;
  localparam int DTRIM_STEP_PPM_X10 = 305;
  localparam int TRIM_SPAN_HI_X10   = 625;
  localparam int TRIM_SPAN_LO_X10   = -615;
  localparam int SEC_BITS           = 15;

  // Trip level counts
  localparam int VDD_TRIP_LEVELS = 6;
  localparam int BAT_TRIP_LEVELS = 7;

  // Timing
  localparam int CLK_HZ             = 100_000_000;
  localparam int OSC_HZ             = 32768;
  localparam int ALARM_PULSE_MS     = 250;
  localparam int ALARM_PULSE_CYCLES = ALARM_PULSE_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcctl_reg_req_t;

  typedef struct packed {
    logic       on_battery;
    logic       main_below_trip;
  } rtcctl_supply_t;

  typedef struct packed {
    logic       auto_clear_enable;
    logic       rtc_write_enable;
    logic       interrupt_mode_select;
    logic       battery_output_disable;
    logic [3:0] clock_output_select;
  } rtcctl_irq_ctrl_t;

  typedef struct packed {
    logic       reserved;
    logic       battery_disconnect_bit;
    logic [2:0] first_battery_trip_field;
    logic [2:0] second_battery_trip_field;
  } rtcctl_bat_trip_t;

  typedef struct packed {
    logic [1:0] coarse_digital_trim;
    logic [5:0] analog_trim_field;
  } rtcctl_trim_t;

  typedef enum logic [1:0] {
    ALM_IDLE,
    ALM_PULSE,
    ALM_HOLD
  } rtcctl_alarm_st_t;

  // Divider tap for each clock output select code above the fixed ones
  function automatic int fo_tap(input logic [3:0] code);
    int tap;
    tap = int'(code) + TAP_OFFSET;
    if (code == FO_DIV_4K) begin
      tap = TAP_4K;
    end else if (code == FO_DIV_1K) begin
      tap = TAP_1K;
    end
    return tap;
  endfunction

endpackage
`default_nettype wire

// *** logic/rtcctl_fout_div.sv ***
`timescale 1ns/10ps
`default_nettype none
module rtcctl_fout_div #(
  parameter int DIV_WIDTH = rtcctl_pkg::DIV_WIDTH
) (
  input  wire logic       clk_in,          // System clock
  input  wire logic       reset_in,        // Sync reset, active high
  input  wire logic       osc_clk_in,      // Oscillator level, synchronous
  input  wire logic [3:0] clk_sel_in,      // Clock output select
  input  wire logic [1:0] dtrim_in,        // Coarse digital trim code
  output logic            fout_level_out,  // Selected square wave
  output logic            tick_out         // Trimmed timekeeping tick
);

  logic                 osc_ff;
  logic                 nxt_osc;
  logic [DIV_WIDTH-1:0] div_ff;
  logic [DIV_WIDTH-1:0] nxt_div;
  logic                 fout_ff;
  logic                 nxt_fout;
  logic                 tick_ff;
  logic                 nxt_tick;
  logic                 ins_ff;
  logic                 nxt_ins;
  logic                 osc_rise;
  logic                 sec_wrap;

  assign fout_level_out = fout_ff;
  assign tick_out       = tick_ff;

  // Divider, output tap select and pulse skip/insert
  always_comb begin
    nxt_osc  = osc_clk_in;
    osc_rise = osc_clk_in & ~osc_ff;
    nxt_div  = osc_rise ? div_ff + 1'b1 : div_ff;
    sec_wrap = osc_rise && (&div_ff[rtcctl_pkg::SEC_BITS-1:0]);
    // Once per second one tick is added or dropped: 1/32768 is the 30.5 ppm step
    nxt_ins  = sec_wrap && (dtrim_in == rtcctl_pkg::DTRIM_PLUS);
    nxt_tick = (osc_rise && !(sec_wrap && dtrim_in == rtcctl_pkg::DTRIM_MINUS))
               || ins_ff;
    case (clk_sel_in)
      rtcctl_pkg::FO_OFF: begin
        nxt_fout = 1'b1;
      end
      rtcctl_pkg::FO_OSC: begin
        nxt_fout = osc_clk_in;
      end
      default: begin
        nxt_fout = div_ff[rtcctl_pkg::fo_tap(clk_sel_in)];
      end
    endcase
  end

  // Register the divider state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      osc_ff  <= 1'b0;
      div_ff  <= '0;
      fout_ff <= 1'b1;
      tick_ff <= 1'b0;
      ins_ff  <= 1'b0;
    end else begin
      osc_ff  <= nxt_osc;
      div_ff  <= nxt_div;
      fout_ff <= nxt_fout;
      tick_ff <= nxt_tick;
      ins_ff  <= nxt_ins;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  trim_skip_a: assert property (
    (osc_clk_in && !osc_ff && (&div_ff[rtcctl_pkg::SEC_BITS-1:0])
     && dtrim_in == rtcctl_pkg::DTRIM_MINUS) |=> !tick_ff)
    else $error("minus trim did not drop a tick");

endmodule
`default_nettype wire

// *** logic/rtcctl_interrupt_clock_pin_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Pulse mode: pin low for 250 ms
// - Level mode: pin low until flag cleared
// - Mode 0 single event, 1 recurring
// - Battery disable releases pin in backup
// - Clock select resets to 32.768 kHz
// - Nonzero clock select overrides alarm output
// - Codes 0-7: off, 32768 to 8 Hz
// - Codes 8-15: 4 Hz down to 1/32 Hz
// - Stamp clear bit clears both timestamps
// - Main trip field picks six thresholds
// - First battery trip at bits 5:3
// - Second battery trip at bits 2:0
// - Disconnect bit isolates backup battery input
// - Main power cycle clears disconnect bit
// - Coarse trim codes: off, +30.5, 0, -30.5
// - Digital trim skips or inserts ticks
// - Analog trim pulls via load capacitance
// - Total trim span +62.5 to -61.5 ppm
// - Host writes only clear alarm flag
// - Supply low flag follows comparator on main
module rtcctl_interrupt_clock_pin_ctrl #(
  parameter int unsigned PULSE_CYCLES = rtcctl_pkg::ALARM_PULSE_CYCLES
) (
  input  wire logic                        clk_in,             // 100 MHz clock
  input  wire logic                        reset_in,           // Sync reset, active high
  input  wire rtcctl_pkg::rtcctl_reg_req_t reg_req_in,         // Register write/address
  output logic [7:0]                       reg_rdata_out,      // Read data, one cycle later
  input  wire logic                        osc_clk_in,         // 32.768 kHz level
  input  wire logic                        alarm_match_in,     // Alarm compare hit pulse
  input  wire logic                        alarm_clear_in,     // Host writes flag to 0
  input  wire logic                        status_read_in,     // Completed status read
  input  wire rtcctl_pkg::rtcctl_supply_t  supply_in,          // Supply mode and compare
  input  wire logic                        irq_pin_in,         // Pin level, unused
  output logic                             irq_pin_out,        // Pin drive value
  output logic                             irq_pin_oe_out,     // High while pulling low
  output logic                             alarm_flag_out,     // Alarm status flag
  output logic                             supply_low_out,     // Supply low flag
  output logic                             alarm_repeat_out,   // Recurring alarm mode
  output logic [2:0]                       vdd_trip_out,       // Main trip code
  output logic [2:0]                       bat85_trip_out,     // First battery trip code
  output logic [2:0]                       bat75_trip_out,     // Second battery trip code
  output logic                             bat_disconnect_out, // Battery input isolated
  output logic                             stamp_clear_out,    // Clear both timestamps
  output logic [1:0]                       dtrim_out,          // Coarse trim code
  output logic [5:0]                       analog_trim_out,    // Load capacitor code
  output logic                             trim_tick_out       // Trimmed timekeeping tick
);

  localparam int PCW = $clog2(PULSE_CYCLES + 1);

  rtcctl_pkg::rtcctl_irq_ctrl_t irq_ctrl_ff;
  rtcctl_pkg::rtcctl_irq_ctrl_t nxt_irq_ctrl;
  rtcctl_pkg::rtcctl_bat_trip_t bat_trip_ff;
  rtcctl_pkg::rtcctl_bat_trip_t nxt_bat_trip;
  rtcctl_pkg::rtcctl_trim_t     trim_ff;
  rtcctl_pkg::rtcctl_trim_t     nxt_trim;
  rtcctl_pkg::rtcctl_alarm_st_t st_ff;
  rtcctl_pkg::rtcctl_alarm_st_t nxt_st;
  logic [2:0]                   vdd_trip_ff;
  logic [2:0]                   nxt_vdd_trip;
  logic                         power_lost_ff;
  logic                         nxt_power_lost;
  logic                         stamp_clr_ff;
  logic                         nxt_stamp_clr;
  logic [7:0]                   rdata_ff;
  logic [7:0]                   nxt_rdata;
  logic                         alarm_flag_ff;
  logic                         nxt_alarm_flag;
  logic                         supply_low_ff;
  logic                         nxt_supply_low;
  logic [PCW-1:0]               pulse_cnt_ff;
  logic [PCW-1:0]               nxt_pulse_cnt;
  logic                         pin_oe_ff;
  logic                         nxt_pin_oe;
  logic                         fout_level;
  logic                         wr_irq;
  logic                         wr_supply;
  logic                         wr_bat;
  logic                         wr_trim;
  logic                         pin_off;

  // Clock output divider and digital trim
  rtcctl_fout_div #(
    .DIV_WIDTH (rtcctl_pkg::DIV_WIDTH)
  ) u_div (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .osc_clk_in     (osc_clk_in),
    .clk_sel_in     (irq_ctrl_ff.clock_output_select),
    .dtrim_in       (trim_ff.coarse_digital_trim),
    .fout_level_out (fout_level),
    .tick_out       (trim_tick_out)
  );

  // Output wiring, straight from registers except irq_pin_out, tied low
  assign irq_pin_out        = 1'b0;
  assign irq_pin_oe_out     = pin_oe_ff;
  assign alarm_flag_out     = alarm_flag_ff;
  assign supply_low_out     = supply_low_ff;
  assign alarm_repeat_out   = irq_ctrl_ff.interrupt_mode_select;
  assign vdd_trip_out       = vdd_trip_ff;
  assign bat85_trip_out     = bat_trip_ff.first_battery_trip_field;
  assign bat75_trip_out     = bat_trip_ff.second_battery_trip_field;
  assign bat_disconnect_out = bat_trip_ff.battery_disconnect_bit;
  assign stamp_clear_out    = stamp_clr_ff;
  assign dtrim_out          = trim_ff.coarse_digital_trim;
  assign analog_trim_out    = trim_ff.analog_trim_field;
  assign reg_rdata_out      = rdata_ff;

  // Write decode
  assign wr_irq    = reg_req_in.wr && reg_req_in.addr == rtcctl_pkg::ADDR_IRQ_CTRL;
  assign wr_supply = reg_req_in.wr && reg_req_in.addr == rtcctl_pkg::ADDR_SUPPLY;
  assign wr_bat    = reg_req_in.wr && reg_req_in.addr == rtcctl_pkg::ADDR_BAT_TRIP;
  assign wr_trim   = reg_req_in.wr && reg_req_in.addr == rtcctl_pkg::ADDR_TRIM;

  // Register file next state and read mux
  always_comb begin
    nxt_irq_ctrl   = irq_ctrl_ff;
    nxt_bat_trip   = bat_trip_ff;
    nxt_trim       = trim_ff;
    nxt_vdd_trip   = vdd_trip_ff;
    nxt_power_lost = power_lost_ff;
    if (wr_irq) begin
      nxt_irq_ctrl = rtcctl_pkg::rtcctl_irq_ctrl_t'(reg_req_in.wdata);
    end
    if (wr_supply) begin
      nxt_vdd_trip = reg_req_in.wdata[rtcctl_pkg::SUPPLY_TRIP_MSB:0];
    end
    // Stamp clear is a command, not stored state
    nxt_stamp_clr = wr_supply
                    && reg_req_in.wdata[rtcctl_pkg::SUPPLY_STAMP_CLR_BIT];
    if (wr_bat) begin
      nxt_bat_trip          = rtcctl_pkg::rtcctl_bat_trip_t'(reg_req_in.wdata);
      nxt_bat_trip.reserved = 1'b0;
    end
    // Coarse trim is stored as written; sensing interlock is the host's job
    if (wr_trim) begin
      nxt_trim = rtcctl_pkg::rtcctl_trim_t'(reg_req_in.wdata);
    end
    // Main loss while isolated is remembered; its return reconnects the battery
    if (bat_trip_ff.battery_disconnect_bit && supply_in.on_battery) begin
      nxt_power_lost = 1'b1;
    end
    if (power_lost_ff && !supply_in.on_battery) begin
      nxt_bat_trip.battery_disconnect_bit = 1'b0;
      nxt_power_lost                      = 1'b0;
    end
    case (reg_req_in.addr)
      rtcctl_pkg::ADDR_IRQ_CTRL: begin
        nxt_rdata = irq_ctrl_ff;
      end
      rtcctl_pkg::ADDR_SUPPLY: begin
        nxt_rdata = {5'h00, vdd_trip_ff};
      end
      rtcctl_pkg::ADDR_BAT_TRIP: begin
        nxt_rdata = bat_trip_ff;
      end
      rtcctl_pkg::ADDR_TRIM: begin
        nxt_rdata = trim_ff;
      end
      default: begin
        nxt_rdata = rtcctl_pkg::RDATA_NONE;
      end
    endcase
  end

  // Register file state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_ctrl_ff   <= rtcctl_pkg::RST_IRQ_CTRL;
      vdd_trip_ff   <= rtcctl_pkg::RST_SUPPLY[rtcctl_pkg::SUPPLY_TRIP_MSB:0];
      bat_trip_ff   <= rtcctl_pkg::RST_BAT_TRIP;
      trim_ff       <= rtcctl_pkg::RST_TRIM;
      power_lost_ff <= 1'b0;
      stamp_clr_ff  <= 1'b0;
      rdata_ff      <= rtcctl_pkg::RDATA_NONE;
    end else begin
      irq_ctrl_ff   <= nxt_irq_ctrl;
      vdd_trip_ff   <= nxt_vdd_trip;
      bat_trip_ff   <= nxt_bat_trip;
      trim_ff       <= nxt_trim;
      power_lost_ff <= nxt_power_lost;
      stamp_clr_ff  <= nxt_stamp_clr;
      rdata_ff      <= nxt_rdata;
    end
  end

  // Flags and alarm output sequencer
  always_comb begin
    // A match in the same cycle as a clear keeps the flag set
    nxt_alarm_flag = alarm_match_in
                     || (alarm_flag_ff && !alarm_clear_in
                         && !(irq_ctrl_ff.auto_clear_enable && status_read_in));
    // Detection only meaningful while running from main supply
    nxt_supply_low = !supply_in.on_battery && supply_in.main_below_trip;
    nxt_st        = st_ff;
    nxt_pulse_cnt = pulse_cnt_ff;
    case (st_ff)
      rtcctl_pkg::ALM_IDLE: begin
        if (alarm_match_in && irq_ctrl_ff.interrupt_mode_select) begin
          nxt_st        = rtcctl_pkg::ALM_PULSE;
          nxt_pulse_cnt = PCW'(PULSE_CYCLES - 1);
        end else if (alarm_match_in) begin
          nxt_st = rtcctl_pkg::ALM_HOLD;
        end
      end
      rtcctl_pkg::ALM_PULSE: begin
        // Matches during the pulse do not stretch it
        if (pulse_cnt_ff == '0) begin
          nxt_st = rtcctl_pkg::ALM_IDLE;
        end else begin
          nxt_pulse_cnt = pulse_cnt_ff - 1'b1;
        end
      end
      rtcctl_pkg::ALM_HOLD: begin
        if (!nxt_alarm_flag) begin
          nxt_st = rtcctl_pkg::ALM_IDLE;
        end
      end
      default: begin
        nxt_st = rtcctl_pkg::ALM_IDLE;
      end
    endcase
    // Pin mux: backup disable, then frequency output, then alarm
    pin_off = irq_ctrl_ff.battery_output_disable && supply_in.on_battery;
    if (pin_off) begin
      nxt_pin_oe = 1'b0;
    end else if (irq_ctrl_ff.clock_output_select != rtcctl_pkg::FO_OFF) begin
      nxt_pin_oe = !fout_level;
    end else begin
      nxt_pin_oe = nxt_st != rtcctl_pkg::ALM_IDLE;
    end
  end

  // Flag and sequencer state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      alarm_flag_ff <= 1'b0;
      supply_low_ff <= 1'b0;
      st_ff         <= rtcctl_pkg::ALM_IDLE;
      pulse_cnt_ff  <= '0;
      pin_oe_ff     <= 1'b0;
    end else begin
      alarm_flag_ff <= nxt_alarm_flag;
      supply_low_ff <= nxt_supply_low;
      st_ff         <= nxt_st;
      pulse_cnt_ff  <= nxt_pulse_cnt;
      pin_oe_ff     <= nxt_pin_oe;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  pulse_start_a: assert property (
    (st_ff == rtcctl_pkg::ALM_IDLE && alarm_match_in
     && irq_ctrl_ff.interrupt_mode_select)
    |=> st_ff == rtcctl_pkg::ALM_PULSE && pulse_cnt_ff == PCW'(PULSE_CYCLES - 1))
    else $error("pulse did not start with full count");

  pulse_count_a: assert property (
    (st_ff == rtcctl_pkg::ALM_PULSE && pulse_cnt_ff != '0)
    |=> st_ff == rtcctl_pkg::ALM_PULSE && pulse_cnt_ff == $past(pulse_cnt_ff) - 1'b1)
    else $error("pulse count did not step down");

  pulse_end_a: assert property (
    (st_ff == rtcctl_pkg::ALM_PULSE && pulse_cnt_ff == '0)
    |=> st_ff == rtcctl_pkg::ALM_IDLE)
    else $error("pulse did not end at zero count");

  hold_until_a: assert property (
    (st_ff == rtcctl_pkg::ALM_HOLD && alarm_flag_ff && !alarm_clear_in
     && !status_read_in) |=> st_ff == rtcctl_pkg::ALM_HOLD)
    else $error("level alarm released before flag clear");

  flag_set_a: assert property (
    alarm_match_in |=> alarm_flag_ff)
    else $error("alarm match did not set flag");

  // Auto clear only wins when no new match lands in the same cycle
  auto_clr_a: assert property (
    (irq_ctrl_ff.auto_clear_enable && status_read_in && !alarm_match_in) |=> !alarm_flag_ff)
    else $error("status read did not auto clear flag");

  bat_off_a: assert property (
    (irq_ctrl_ff.battery_output_disable && supply_in.on_battery) |=> !pin_oe_ff)
    else $error("pin driven in backup while disabled");

  fout_prio_a: assert property (
    (irq_ctrl_ff.clock_output_select != rtcctl_pkg::FO_OFF
     && !(irq_ctrl_ff.battery_output_disable && supply_in.on_battery))
    |=> pin_oe_ff == !$past(fout_level))
    else $error("clock output lost priority on pin");

  idle_release_a: assert property (
    (irq_ctrl_ff.clock_output_select == rtcctl_pkg::FO_OFF
     && st_ff == rtcctl_pkg::ALM_IDLE && !alarm_match_in) |=> !pin_oe_ff)
    else $error("pin pulled with no alarm pending");

  fo_reset_a: assert property (
    $past(reset_in) |-> irq_ctrl_ff.clock_output_select == rtcctl_pkg::FO_OSC)
    else $error("clock select not at default after reset");

  stamp_clr_a: assert property (
    (wr_supply && reg_req_in.wdata[rtcctl_pkg::SUPPLY_STAMP_CLR_BIT])
    |=> stamp_clear_out ##1 (!stamp_clear_out || $past(wr_supply)))
    else $error("stamp clear not a single pulse");

  reseal_set_a: assert property (
    (wr_bat && reg_req_in.wdata[6] && !power_lost_ff) |=> bat_disconnect_out)
    else $error("disconnect bit not taken");

  reseal_clear_a: assert property (
    (power_lost_ff && !supply_in.on_battery) |=> !bat_disconnect_out)
    else $error("disconnect not cleared on main return");

  supply_low_a: assert property (
    (!supply_in.on_battery && supply_in.main_below_trip) |=> supply_low_out)
    else $error("supply low flag not set");

  rsvd_zero_a: assert property (
    reg_req_in.addr == rtcctl_pkg::ADDR_SUPPLY |=> reg_rdata_out[7:3] == 5'h00)
    else $error("supply register upper bits not zero");

  pulse_c: cover property (
    st_ff == rtcctl_pkg::ALM_PULSE && pulse_cnt_ff == '0);
  hold_c: cover property (
    st_ff == rtcctl_pkg::ALM_HOLD ##1 st_ff == rtcctl_pkg::ALM_IDLE);
  fout_c: cover property (
    irq_ctrl_ff.clock_output_select != rtcctl_pkg::FO_OFF && $rose(pin_oe_ff));
  reseal_c: cover property (
    $fell(bat_disconnect_out));
  auto_clr_c: cover property (
    alarm_flag_ff && status_read_in && irq_ctrl_ff.auto_clear_enable);

endmodule
`default_nettype wire

// *** bench/rtcctl_osc_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Far side: crystal level source and pulled-up open-drain pin
module rtcctl_osc_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_in,  // System clock
  input  wire logic oe_in,   // Pin pulled low when high
  output logic      osc_out, // Oscillator level, clock synchronous
  output logic      pin_out  // Resolved pin level
);
  int cnt = 0;
  initial osc_out = 1'b0;
  // Ratio shrunk to 8 clocks per oscillator period to keep runs short
  always @(posedge clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      osc_out <= ~osc_out;
    end
  end
  // Pull-up wins whenever nobody pulls low
  assign pin_out = oe_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** bench/test_rtc_interrupt_clock_pin_supply_trim_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_rtc_interrupt_clock_pin_supply_trim_ctrl;
  localparam int unsigned PC = 20;
  logic clk_in, reset_in, osc, pin, oe, pdrv, flag, slow, rep, disc, sclr, tick;
  logic [7:0] rdata;
  logic [2:0] ev, vdd, b85, b75;
  logic [1:0] dtrim;
  logic [5:0] atrim;
  rtcctl_pkg::rtcctl_reg_req_t req;
  rtcctl_pkg::rtcctl_supply_t  supply;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  rtcctl_osc_model PARTNER (.clk_in(clk_in), .oe_in(oe), .osc_out(osc), .pin_out(pin));
  rtcctl_interrupt_clock_pin_ctrl #(.PULSE_CYCLES(PC)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .osc_clk_in(osc), .alarm_match_in(ev[0]), .alarm_clear_in(ev[1]),
    .status_read_in(ev[2]), .supply_in(supply), .irq_pin_in(pin), .irq_pin_out(pdrv),
    .irq_pin_oe_out(oe), .alarm_flag_out(flag), .supply_low_out(slow),
    .alarm_repeat_out(rep), .vdd_trip_out(vdd), .bat85_trip_out(b85),
    .bat75_trip_out(b75), .bat_disconnect_out(disc), .stamp_clear_out(sclr),
    .dtrim_out(dtrim), .analog_trim_out(atrim), .trim_tick_out(tick));
  task automatic summarize();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  // Read data lands one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    req.addr <= a;
    @(posedge clk_in);
    #1 chk("rdata", exp, rdata);
  endtask
  task automatic strobe(input logic [2:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 3'h0;
    #1;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // Pin must mirror the crystal once its level has settled
  task automatic follow();
    logic [2:0] h;
    h = 3'b010;
    // Only judge once three real samples are in the history
    for (int i = 0; i < 24; i++) begin
      cyc(1);
      h = {h[1:0], osc};
      if (i > 1 && (h == 3'b000 || h == 3'b111)) begin
        chk("pin_clk", !osc, oe);
      end
    end
  endtask
  // Cycles to the next rising pull-down; bounded so a dead pin ends the run
  task automatic rise();
    logic p;
    n = 0;
    p = oe;
    while (!(p === 1'b0 && oe === 1'b1)) begin
      p = oe;
      cyc(1);
      n++;
      if (n > 40000) begin
        num_errors++;
        summarize();
      end
    end
  endtask
  initial begin
    reset_in = 1'b1;
    req = '0;
    ev = 3'h0;
    supply = '0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(8'h08, 8'h01);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    rd(8'h3c, 8'h00);
    chk("pin_drive", 0, pdrv);
    follow();
    $display("reset test done");
    // Divided outputs: 8 clocks per crystal period
    for (int i = 2; i < 5; i++) begin
      wr(8'h08, 8'(i));
      // The select switch can fake a first edge, so measure the third
      repeat (3) rise();
      chk("period", 8 * 32768 / ((i == 2) ? 4096 : (i == 3) ? 1024 : 64), n);
    end
    $display("frequency test done");
    wr(8'h09, 8'hfd);
    #1 chk("stamp_clear", 1, sclr);
    chk("vdd_trip", 5, vdd);
    cyc(1);
    chk("stamp_clear", 0, sclr);
    rd(8'h09, 8'h05);
    @(posedge clk_in) supply <= '{on_battery: 1'b0, main_below_trip: 1'b1};
    cyc(3);
    chk("supply_low", 1, slow);
    @(posedge clk_in) supply <= '{on_battery: 1'b1, main_below_trip: 1'b1};
    cyc(3);
    chk("supply_low", 0, slow);
    @(posedge clk_in) supply <= '0;
    wr(8'h0a, 8'hde);
    rd(8'h0a, 8'h5e);
    chk("bat85", 3, b85);
    chk("bat75", 6, b75);
    chk("disconnect", 1, disc);
    @(posedge clk_in) supply <= '{on_battery: 1'b1, main_below_trip: 1'b0};
    cyc(3);
    @(posedge clk_in) supply <= '0;
    cyc(4);
    chk("disconnect", 0, disc);
    // Temperature sensing is never enabled here, so trim may change
    wr(8'h0b, 8'hc5);
    rd(8'h0b, 8'hc5);
    chk("dtrim", 3, dtrim);
    chk("atrim", 5, atrim);
    // One tick per rising crystal edge away from the once-a-second wrap
    n = 0;
    repeat (80) begin
      cyc(1);
      n += int'(tick);
    end
    chk("ticks", 10, n);
    $display("register test done");
    // Pulse mode fires on each match for a fixed width
    wr(8'h08, 8'h20);
    #1 chk("repeat", 1, rep);
    repeat (2) begin
      strobe(3'h1);
      for (n = 0; oe === 1'b1 && n < 1000; n++) cyc(1);
      chk("pulse_len", PC, n);
      strobe(3'h2);
    end
    // Level mode holds until host clears; read without auto clear keeps flag
    wr(8'h08, 8'h00);
    strobe(3'h1);
    cyc(PC + 10);
    chk("level_hold", 1, oe);
    strobe(3'h4);
    chk("flag", 1, flag);
    strobe(3'h2);
    cyc(1);
    chk("level_rel", 0, oe);
    chk("flag", 0, flag);
    // Auto clear: a match during the read survives, a plain read clears
    wr(8'h08, 8'h80);
    strobe(3'h5);
    chk("flag", 1, flag);
    strobe(3'h4);
    chk("flag", 0, flag);
    chk("auto_rel", 0, oe);
    @(posedge clk_in) supply <= '{on_battery: 1'b1, main_below_trip: 1'b0};
    wr(8'h08, 8'h10);
    strobe(3'h1);
    cyc(3);
    chk("bat_off", 0, oe);
    strobe(3'h2);
    @(posedge clk_in) supply <= '0;
    wr(8'h08, 8'h01);
    strobe(3'h1);
    follow();
    $display("alarm test done");
    summarize();
  end
endmodule
`default_nettype wire
